/* hw/wtd_timer.sv */
`timescale 1ns/1ps
module wtd_timer
  import wtd_pkg::*;
#(
  parameter int TICK_DIV = TICK_DIV_DEF
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [2:0]  port_data_out,
  input  wire logic        narrow_timer_output,
  input  wire logic        narrow_done,
  input  wire logic        alt_demod_input_pin,
  input  wire logic        shared_demod_irq_pin,
  output logic             narrow_output_pin,
  output logic             wide_output_pin,
  output logic             combined_output_pin,
  output logic             wide_timer_output,
  output logic             wide_done,
  output logic             timeout_irq,
  output logic             capture_irq,
  output logic             capture_pin_interrupt
);
  if (TICK_DIV < 1 || TICK_DIV > 65535) begin : g_chk
    $error("TICK_DIV out of range");
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  logic [7:0]  ntc_reg, com_reg, wtc_reg, imr_reg;
  logic [7:0]  rld_hi_reg, rld_lo_reg, cap_hi_reg, cap_lo_reg;
  logic [1:0]  edge_flag_reg;
  logic        to_flag_reg, ack_reg, en_d_reg, wout_reg;
  logic        filt_reg, prev_reg;
  logic [3:0]  flt_cnt_reg, need;
  logic [15:0] cnt_reg, tick_cnt_reg;
  logic [7:0]  rd_byte;
  wtd_state_t  state_reg;

  wire         req     = avs_read | avs_write;
  wire         wr_fire = avs_write & ack_reg & avs_byteenable[0];
  wire [2:0]   idx     = avs_address[4:2];
  wire [7:0]   wdat    = avs_writedata[7:0];
  wire         demod   = com_reg[COM_MODE];
  wire [1:0]   sub     = com_reg[COM_SUB_HI:COM_SUB_LO];
  wire [1:0]   esel    = com_reg[COM_SEL_HI:COM_SEL_LO];
  wire         en      = wtc_reg[WCT_EN];
  wire [15:0]  reload  = {rld_hi_reg, rld_lo_reg};
  wire         start   = en & ~en_d_reg;
  wire         tick    = (tick_cnt_reg == 16'(TICK_DIV - 1));
  wire         raw_in  = com_reg[COM_PINSEL] ? shared_demod_irq_pin : alt_demod_input_pin;
  wire         rise    = filt_reg & ~prev_reg;
  wire         fall    = ~filt_reg & prev_reg;
  wire         edge_hit;
  wire         to_ev, cap_ev;

  // single wait state: request seen, answered on the next edge
  assign avs_waitrequest = req & ~ack_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  always_comb begin
    case (idx)
      IDX_NARROW_CTL: rd_byte = ntc_reg;
      IDX_COMMON:     rd_byte = demod ? {com_reg[7:2], edge_flag_reg} : com_reg;
      IDX_WIDE_CTL:   rd_byte = {wtc_reg[7:6], to_flag_reg, wtc_reg[4:0]};
      IDX_RLD_HI:     rd_byte = rld_hi_reg;
      IDX_RLD_LO:     rd_byte = rld_lo_reg;
      IDX_CAP_HI:     rd_byte = cap_hi_reg;
      IDX_CAP_LO:     rd_byte = cap_lo_reg;
      IDX_IMR:        rd_byte = imr_reg;
      default:        rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack_reg) begin
      avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

  // control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ntc_reg <= CTL_RST;
      com_reg <= CTL_RST;
      wtc_reg <= CTL_RST;
      imr_reg <= CTL_RST;
    end else if (wr_fire) begin
      case (idx)
        IDX_NARROW_CTL: ntc_reg <= wdat;
        // in demod the low bits are flags, keep initial levels intact
        IDX_COMMON: com_reg <= wdat[COM_MODE] ? {wdat[7:2], com_reg[1:0]} : wdat;
        IDX_WIDE_CTL: wtc_reg <= {wdat[7:6], 1'b0, wdat[4:0]};
        IDX_IMR: imr_reg <= wdat;
        default: ;
      endcase
    end
  end

  // reload bytes only latched here, counter samples them on reload
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rld_hi_reg <= RLD_RST;
      rld_lo_reg <= RLD_RST;
    end else if (wr_fire) begin
      if (idx == IDX_RLD_HI) rld_hi_reg <= wdat;
      if (idx == IDX_RLD_LO) rld_lo_reg <= wdat;
    end
  end

  // sticky flags, hardware set wins over write-1 clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      to_flag_reg   <= 1'b0;
      edge_flag_reg <= 2'b00;
    end else begin
      if (to_ev) begin
        to_flag_reg <= 1'b1;
      end else if (wr_fire && idx == IDX_WIDE_CTL && wdat[WCT_TO]) begin
        to_flag_reg <= 1'b0;
      end
      for (int i = 0; i < 2; i++) begin
        if (cap_ev && (i == 1 ? rise : fall)) begin
          edge_flag_reg[i] <= 1'b1;
        end else if (wr_fire && idx == IDX_COMMON && demod && wdat[i]) begin
          edge_flag_reg[i] <= 1'b0;
        end
      end
    end
  end

  // timer tick divider
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
    end
  end

  // glitch filter: input must differ this many cycles to be taken
  always_comb begin
    case (sub)
      SUB_PPONG:  need = FILT_SHORT;
      SUB_FORCE0: need = FILT_LONG;
      default:    need = FILT_NONE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filt_reg    <= 1'b0;
      prev_reg    <= 1'b0;
      flt_cnt_reg <= 4'h0;
    end else begin
      prev_reg <= filt_reg;
      if (raw_in == filt_reg) begin
        flt_cnt_reg <= 4'h0;
      end else if (flt_cnt_reg + 4'h1 >= need) begin
        filt_reg    <= raw_in;
        flt_cnt_reg <= 4'h0;
      end else begin
        flt_cnt_reg <= flt_cnt_reg + 4'h1;
      end
    end
  end

  assign edge_hit = demod & en & (esel == EDGE_FALL ? fall :
                                  esel == EDGE_RISE ? rise : (rise | fall));
  assign to_ev  = ~demod & en & (state_reg == ST_RUN) & tick & (cnt_reg == WIDE_ONE);
  assign cap_ev = edge_hit & ((state_reg == ST_WAIT) |
                  ((state_reg == ST_RUN) & ~wtc_reg[WCT_CAPM]));

  // wide counter and its sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= WIDE_ZERO;
      en_d_reg  <= 1'b0;
    end else begin
      en_d_reg <= en;
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            cnt_reg   <= reload;
            state_reg <= demod ? ST_WAIT : ST_RUN;
          end
        end
        ST_RUN: begin
          if (!en) begin
            state_reg <= ST_IDLE;
          end else if (cap_ev) begin
            cnt_reg <= reload;
          end else if (to_ev) begin
            if (sub == SUB_PPONG) begin
              cnt_reg   <= WIDE_ZERO;
              state_reg <= ST_WAIT;
            end else if (wtc_reg[WCT_MOD]) begin
              cnt_reg <= reload;
            end else begin
              cnt_reg   <= WIDE_ZERO;
              state_reg <= ST_IDLE;
            end
          end else if (tick) begin
            cnt_reg <= cnt_reg - WIDE_ONE;
          end
        end
        ST_WAIT: begin
          if (!en) begin
            state_reg <= ST_IDLE;
          end else if (demod ? edge_hit : narrow_done) begin
            cnt_reg   <= reload;
            state_reg <= ST_RUN;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // capture of complemented count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cap_hi_reg <= CAP_RST;
      cap_lo_reg <= CAP_RST;
    end else if (cap_ev) begin
      {cap_hi_reg, cap_lo_reg} <= ~cnt_reg;
    end
  end

  // wide output level and event pulses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wout_reg              <= 1'b0;
      wide_timer_output     <= 1'b1;
      timeout_irq           <= 1'b0;
      capture_irq           <= 1'b0;
      capture_pin_interrupt <= 1'b0;
      wide_done             <= 1'b0;
    end else begin
      if (start) begin
        wout_reg <= com_reg[COM_INIT_W];
      end else if (to_ev) begin
        wout_reg <= ~wout_reg;
      end
      if (!demod && sub == SUB_FORCE0) begin
        wide_timer_output <= 1'b0;
      end else if (!demod && sub == SUB_FORCE1) begin
        wide_timer_output <= 1'b1;
      end else if (!en) begin
        wide_timer_output <= ~com_reg[COM_INIT_W];
      end else begin
        wide_timer_output <= start ? com_reg[COM_INIT_W] : wout_reg;
      end
      timeout_irq           <= to_ev & wtc_reg[WCT_TIE];
      wide_done             <= to_ev & (sub == SUB_PPONG);
      capture_irq           <= cap_ev & wtc_reg[WCT_CIE];
      capture_pin_interrupt <= cap_ev & com_reg[COM_PINSEL] & imr_reg[IMR_CAP];
    end
  end

  // combined output: and / or / nor / nand picked by bits 5:4
  function automatic logic combine(input logic [1:0] op, input logic a, input logic b);
    case (op)
      2'h0:    combine = a & b;
      2'h1:    combine = a | b;
      2'h2:    combine = ~(a | b);
      default: combine = ~(a & b);
    endcase
  endfunction

  // pins registered so they never glitch on a mode write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      narrow_output_pin   <= 1'b0;
      wide_output_pin     <= 1'b0;
      combined_output_pin <= 1'b0;
    end else begin
      narrow_output_pin <= ntc_reg[NCT_OUT] ? narrow_timer_output : port_data_out[0];
      wide_output_pin   <= wtc_reg[WCT_OUT] ? wide_timer_output : port_data_out[1];
      combined_output_pin <= (!demod && com_reg[COM_PINSEL]) ?
        combine(esel, narrow_timer_output, wide_timer_output) : port_data_out[2];
    end
  end

  property p_to_irq;
    to_ev && wtc_reg[WCT_TIE] |=> timeout_irq && to_flag_reg;
  endproperty
  a_to_irq: assert property (p_to_irq) else $error("timeout event lost");

  property p_force;
    !demod && sub == SUB_FORCE1 |=> wide_timer_output;
  endproperty
  a_force: assert property (p_force) else $error("forced high missing");

  property p_idle_out;
    !demod && !sub[1] && !en |=> wide_timer_output == !$past(com_reg[COM_INIT_W]);
  endproperty
  a_idle_out: assert property (p_idle_out) else $error("disabled level wrong");

  property p_load;
    state_reg == ST_IDLE && start |=> cnt_reg == $past(reload);
  endproperty
  a_load: assert property (p_load) else $error("enable load wrong");

  property p_single;
    to_ev && !wtc_reg[WCT_MOD] && sub != SUB_PPONG |=> state_reg == ST_IDLE ##1
      $stable(cnt_reg);
  endproperty
  a_single: assert property (p_single) else $error("single pass not stopped");

  property p_wrap;
    !demod && en && state_reg == ST_RUN && tick && cnt_reg == WIDE_ZERO
      |=> cnt_reg == 16'hffff && !timeout_irq && !$rose(to_flag_reg);
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap treated as timeout");

  property p_cap;
    cap_ev |=> {cap_hi_reg, cap_lo_reg} == ~$past(cnt_reg) && state_reg == ST_RUN;
  endproperty
  a_cap: assert property (p_cap) else $error("capture value wrong");

  property p_flag;
    cap_ev && rise |=> edge_flag_reg[1] && (capture_irq == $past(wtc_reg[WCT_CIE]));
  endproperty
  a_flag: assert property (p_flag) else $error("edge flag not set");

  property p_pin_irq;
    capture_pin_interrupt |-> $past(cap_ev) && $past(imr_reg[IMR_CAP]);
  endproperty
  a_pin_irq: assert property (p_pin_irq) else $error("pin interrupt unmasked");

  property p_hold;
    state_reg == ST_RUN && en && !tick && !cap_ev |=> $stable(cnt_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved off tick");
endmodule

/* hw/wtd_pkg.sv */
package wtd_pkg;
  // register word indices, byte address = index * 4
  localparam logic [2:0] IDX_NARROW_CTL = 3'h0;
  localparam logic [2:0] IDX_COMMON     = 3'h1;
  localparam logic [2:0] IDX_WIDE_CTL   = 3'h2;
  localparam logic [2:0] IDX_RLD_HI     = 3'h3;
  localparam logic [2:0] IDX_RLD_LO     = 3'h4;
  localparam logic [2:0] IDX_CAP_HI     = 3'h5;
  localparam logic [2:0] IDX_CAP_LO     = 3'h6;
  localparam logic [2:0] IDX_IMR        = 3'h7;
  // timer_common_control fields
  localparam int COM_MODE   = 7;
  localparam int COM_PINSEL = 6;
  localparam int COM_SEL_HI = 5;
  localparam int COM_SEL_LO = 4;
  localparam int COM_SUB_HI = 3;
  localparam int COM_SUB_LO = 2;
  localparam int COM_INIT_N = 1;
  localparam int COM_INIT_W = 0;
  // wide_timer_control fields, then the narrow control and imr bits
  localparam int WCT_EN   = 7;
  localparam int WCT_CAPM = 6;
  localparam int WCT_TO   = 5;
  localparam int WCT_MOD  = 4;
  localparam int WCT_CIE  = 2;
  localparam int WCT_TIE  = 1;
  localparam int WCT_OUT  = 0;
  localparam int NCT_OUT  = 0;
  localparam int IMR_CAP  = 2;
  // reset values
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] RLD_RST = 8'h00;
  localparam logic [7:0] CAP_RST = 8'h00;
  // counts
  localparam logic [3:0]  FILT_NONE  = 4'h1;
  localparam logic [3:0]  FILT_SHORT = 4'h4;
  localparam logic [3:0]  FILT_LONG  = 4'h8;
  localparam logic [15:0] WIDE_ONE   = 16'h0001;
  localparam logic [15:0] WIDE_ZERO  = 16'h0000;
  localparam int          TICK_DIV_DEF = 1;
  // transmit submodes / filter choices share these codes
  localparam logic [1:0] SUB_NORMAL = 2'h0;
  localparam logic [1:0] SUB_PPONG  = 2'h1;
  localparam logic [1:0] SUB_FORCE0 = 2'h2;
  localparam logic [1:0] SUB_FORCE1 = 2'h3;
  // demod edge choice
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN  = 3'b010,
    ST_WAIT = 3'b100
  } wtd_state_t;
endpackage

/* sim/wtd_sig_src.sv */
`timescale 1ns/1ps
// square wave source for the demodulator input pins
module wtd_sig_src (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic       sel,
  input  wire logic [7:0] half_per,
  output logic            alt_pin,
  output logic            shr_pin
);
  logic       lvl_reg;
  logic [7:0] cnt_reg;
  // idle line rests low so a stop shows as a falling edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lvl_reg <= 1'b0;
      cnt_reg <= 8'h00;
    end else if (!run) begin
      lvl_reg <= 1'b0;
      cnt_reg <= 8'h00;
    end else if (cnt_reg + 8'h01 >= half_per) begin
      lvl_reg <= !lvl_reg;
      cnt_reg <= 8'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
  // unselected pin stays quiet
  assign alt_pin = !sel & lvl_reg;
  assign shr_pin = sel & lvl_reg;
endmodule

/* sim/testbench.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, a, e); end end
module testbench;
  import wtd_pkg::*;
  logic        clk, rst, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic [2:0]  port_data_out;
  logic        narrow_timer_output, narrow_done, alt_demod_input_pin;
  logic        shared_demod_irq_pin, narrow_output_pin, wide_output_pin;
  logic        combined_output_pin, wide_timer_output, wide_done;
  logic        timeout_irq, capture_irq, capture_pin_interrupt;
  logic        run, sel;
  logic [7:0]  hp, q, h;
  int          n_fail = 0, n_compared = 0, cyc = 0, tk, hit, d, tw;
  wtd_timer #(.TICK_DIV(1)) u_dut (.clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .port_data_out, .narrow_timer_output, .narrow_done,
    .alt_demod_input_pin, .shared_demod_irq_pin, .narrow_output_pin,
    .wide_output_pin, .combined_output_pin, .wide_timer_output, .wide_done,
    .timeout_irq, .capture_irq, .capture_pin_interrupt);
  wtd_sig_src u_src (.clk(clk), .rst(rst), .run(run), .sel(sel),
    .half_per(hp), .alt_pin(alt_demod_input_pin),
    .shr_pin(shared_demod_irq_pin));
  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic test_done();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [2:0] i, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= {i, 2'h0};
    avs_writedata <= {24'h0, v};
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (avs_waitrequest !== 1'b0) begin
      n_fail++;
      test_done();
    end
    q = avs_readdata[7:0];
    tk = cyc;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [2:0] i, input logic [7:0] v);
    bus(1'b1, i, v);
  endtask
  task automatic rd(input logic [2:0] i);
    bus(1'b0, i, 8'h00);
  endtask
  // waits for a pulse: 0 timeout, 1 capture, 2 pin interrupt; d=-1 if none
  task automatic evt(input int k, input int lim);
    int t;
    t = cyc;
    d = -1;
    while (d < 0 && cyc - t < lim) begin
      @(negedge clk);
      if ((k == 0 ? timeout_irq : k == 1 ? capture_irq
           : capture_pin_interrupt) === 1'b1) d = cyc - t;
    end
    hit = cyc;
  endtask
  initial begin
    {avs_read, avs_write, narrow_timer_output, narrow_done, run, sel} = '0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = 4'h1;
    port_data_out = 3'h5;
    hp = 8'h1e;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0]);
      `CHK(q, 8'h00)
    end
    `CHK(wide_timer_output, 1'b1)
    `CHK({combined_output_pin, wide_output_pin, narrow_output_pin}, 3'h5)
    wr(IDX_COMMON, 8'h01);
    repeat (2) @(negedge clk);
    `CHK(wide_timer_output, 1'b0)
    for (int k = 2; k < 4; k++) begin
      wr(IDX_COMMON, {4'h0, k[1:0], 2'h0});
      repeat (2) @(negedge clk);
      `CHK(wide_timer_output, k[0])
    end
    // combine ops AND, OR, NOR, NAND with narrow 0, wide 1
    wr(IDX_NARROW_CTL, 8'h01);
    wr(IDX_WIDE_CTL, 8'h01);
    for (int k = 0; k < 4; k++) begin
      wr(IDX_COMMON, {2'h1, k[1:0], 4'h0});
      repeat (3) @(negedge clk);
      `CHK({combined_output_pin, wide_output_pin, narrow_output_pin}, {k[0], 2'h2})
    end
    // reload values never one
    wr(IDX_COMMON, 8'h01);
    wr(IDX_RLD_LO, 8'h05);
    wr(IDX_WIDE_CTL, 8'h82);
    evt(0, 200);
    `CHK(d, 7)
    @(negedge clk);
    `CHK(wide_timer_output, 1'b0)
    rd(IDX_WIDE_CTL);
    `CHK(q, 8'ha2)
    evt(0, 60);
    `CHK(d, -1)
    wr(IDX_WIDE_CTL, 8'h20);
    rd(IDX_WIDE_CTL);
    `CHK(q, 8'h00)
    wr(IDX_COMMON, 8'h00);
    wr(IDX_RLD_LO, 8'h14);
    wr(IDX_WIDE_CTL, 8'h92);
    tw = tk;
    wr(IDX_RLD_LO, 8'h06);
    `CHK(wide_timer_output, 1'b0)
    evt(0, 100);
    `CHK(hit - tw, 22)
    evt(0, 30);
    `CHK(d inside {[6:7]}, 1'b1)
    wr(IDX_WIDE_CTL, 8'h00);
    wr(IDX_RLD_LO, 8'h00);
    wr(IDX_WIDE_CTL, 8'h82);
    evt(0, 300);
    `CHK(d, -1)
    // ping-pong waits for the narrow timer before reloading
    wr(IDX_WIDE_CTL, 8'h00);
    wr(IDX_RLD_LO, 8'h05);
    wr(IDX_COMMON, 8'h04);
    wr(IDX_WIDE_CTL, 8'h92);
    evt(0, 50);
    `CHK(wide_done, 1'b1)
    evt(0, 40);
    `CHK(d, -1)
    @(posedge clk) narrow_done <= 1'b1;
    @(posedge clk) narrow_done <= 1'b0;
    evt(0, 40);
    `CHK(d > 0, 1'b1)
    wr(IDX_WIDE_CTL, 8'h00);
    wr(IDX_RLD_HI, 8'hff);
    wr(IDX_RLD_LO, 8'hff);
    wr(IDX_COMMON, 8'ha0);
    wr(IDX_WIDE_CTL, 8'h84);
    run <= 1'b1;
    evt(1, 100);
    `CHK(d > 0, 1'b1)
    evt(1, 100);
    rd(IDX_CAP_HI);
    h = q;
    rd(IDX_CAP_LO);
    `CHK({h, q} inside {[16'd29:16'd31]}, 1'b1)
    rd(IDX_COMMON);
    `CHK(q, 8'ha3)
    run <= 1'b0;
    repeat (10) @(negedge clk);
    wr(IDX_COMMON, 8'ha3);
    rd(IDX_COMMON);
    `CHK(q, 8'ha0)
    // a 2-cycle level never survives the 4-cycle filter
    wr(IDX_COMMON, 8'ha4);
    hp <= 8'h02;
    run <= 1'b1;
    evt(1, 60);
    `CHK(d, -1)
    hp <= 8'h0a;
    evt(1, 60);
    `CHK(d > 0, 1'b1)
    wr(IDX_IMR, 8'h04);
    wr(IDX_COMMON, 8'he0);
    sel <= 1'b1;
    evt(2, 100);
    `CHK(d > 0, 1'b1)
    wr(IDX_IMR, 8'h00);
    evt(2, 60);
    `CHK(d, -1)
    sel <= 1'b0;
    repeat (10) @(negedge clk);
    evt(1, 60);
    `CHK(d, -1)
    test_done();
  end
endmodule
